// ### hdl/cpa_regs.svh
/*
  Constants for the card access controller and its terminal supervisor.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef CPA_REGS_SVH
`define CPA_REGS_SVH
// Clock and supervision times
`define CPA_CLK_HZ          40000000
`define CPA_STATUS_PERIOD_S 30
`define CPA_RSP_LIMIT_S     5
// Field widths and positions
`define CPA_CODE_W          16
`define CPA_DATA_W          32
`define CPA_DIR_W           16
`define CPA_SVC_W           32
`define CPA_SVC_DISABLE_BIT 0
// Blocking threshold
`define CPA_MAX_FAILS       2'h3
// Directories
`define CPA_DIR_MASTER      16'h3f00
`define CPA_DIR_APP         16'h7f90
// Reset values of the stored codes and of the challenge LFSR
`define CPA_PRI_RST         16'h1234
`define CPA_SEC_RST         16'h5678
`define CPA_PRI_UNBLK_RST   16'h8888
`define CPA_SEC_UNBLK_RST   16'h9999
`define CPA_LFSR_RST        32'h0000_0001
`endif

// ### hdl/cpa_pkg.sv
/*
  Types shared by both ends of the card command link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cpa_pkg;
  typedef enum logic [3:0] {
    OP_NONE     = 4'h0,
    OP_SELECT   = 4'h1,
    OP_STATUS   = 4'h2,
    OP_VERIFY   = 4'h3,
    OP_CHANGE   = 4'h4,
    OP_DISABLE  = 4'h5,
    OP_ENABLE   = 4'h6,
    OP_UNBLOCK  = 4'h7,
    OP_ALG_CARD = 4'h8,
    OP_GET_RESP = 4'h9,
    OP_GET_CHAL = 4'ha,
    OP_ALG_NET  = 4'hb,
    OP_KEY_COMB = 4'hc,
    OP_SES_END  = 4'hd
  } cpa_op_t;

  typedef enum logic [2:0] {
    ST_OK       = 3'h0,
    ST_MISMATCH = 3'h1,
    ST_BLOCKED  = 3'h2,
    ST_REFUSED  = 3'h3,
    ST_NO_SVC   = 3'h4,
    ST_NO_RSP   = 3'h5
  } cpa_status_t;

  typedef enum logic [1:0] {
    AM_NONE = 2'h0,
    AM_CARD = 2'h1,
    AM_NET  = 2'h2
  } cpa_auth_t;
endpackage

// ### hdl/cpa_link_if.sv
/*
  Command/response link between terminal (master) and card (slave).
  Assumes both ends run on the same clock; one command outstanding at a time.
*/
`timescale 1ns/1ps
`include "cpa_regs.svh"
interface cpa_link_if;
  import cpa_pkg::*;
  logic                   cmd_valid;
  cpa_op_t                cmd_op;
  logic                   cmd_sel;
  logic [`CPA_CODE_W-1:0] cmd_val;
  logic [`CPA_CODE_W-1:0] cmd_new;
  logic [`CPA_DATA_W-1:0] cmd_arg;
  logic                   rsp_valid;
  cpa_status_t            rsp_status;
  logic [`CPA_DATA_W-1:0] rsp_data;
  logic [`CPA_DIR_W-1:0]  rsp_dir;
  logic                   rsp_flag;

  modport card (input cmd_valid, cmd_op, cmd_sel, cmd_val, cmd_new, cmd_arg,
                output rsp_valid, rsp_status, rsp_data, rsp_dir, rsp_flag);
  modport term (output cmd_valid, cmd_op, cmd_sel, cmd_val, cmd_new, cmd_arg,
                input rsp_valid, rsp_status, rsp_data, rsp_dir, rsp_flag);
endinterface

// ### hdl/cpa_card.sv
/*
  Card end: secret-code state machine, access rights, algorithm gating.
  Assumes the terminal issues one command at a time and waits for the answer,
  which comes one cycle after the command is taken.
*/
`timescale 1ns/1ps
`include "cpa_regs.svh"
module cpa_card
  import cpa_pkg::*;
#(
  parameter logic [`CPA_DATA_W-1:0] AUTH_KEY = 32'h5a5a_0f0f  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // Link to terminal
  cpa_link_if.card                    link,
  // Card configuration
  input  wire logic [`CPA_SVC_W-1:0]  service_table_file,
  input  wire logic                   mutual_auth_setting_file,
  // Card state
  output logic      [1:0]             access_right,
  output logic      [3:0]             code_blocked,
  output logic                        primary_enabled,
  output logic      [`CPA_DATA_W-1:0] session_cipher_key,
  output logic                        key_valid
);
  localparam logic [`CPA_CODE_W-1:0] CODE_RST [4] =
    '{`CPA_PRI_RST, `CPA_SEC_RST, `CPA_PRI_UNBLK_RST, `CPA_SEC_UNBLK_RST};

  // Codes: 0 primary, 1 secondary, 2 and 3 their unblocking keys
  logic [`CPA_CODE_W-1:0] code_q [4];
  logic [`CPA_CODE_W-1:0] code_d [4];
  logic [1:0]             fail_q [4];
  logic [1:0]             fail_d [4];
  logic [3:0]             blk_q, blk_d;
  logic                   en_q, en_d;
  logic [1:0]             right_q, right_d;
  logic [`CPA_DIR_W-1:0]  dir_q, dir_d;
  logic [`CPA_DATA_W-1:0] lfsr_q, lfsr_d;
  logic [`CPA_DATA_W-1:0] chal_q, chal_d;
  logic [`CPA_DATA_W-1:0] res_q, res_d;
  logic [`CPA_DATA_W-1:0] part1_q, part1_d;
  logic [`CPA_DATA_W-1:0] part2_q, part2_d;
  logic [`CPA_DATA_W-1:0] key_q, key_d;
  logic                   res_rdy_q, res_rdy_d;
  logic                   res_sent_q, res_sent_d;
  logic                   chal_ok_q, chal_ok_d;
  logic                   net_ok_q, net_ok_d;
  logic                   net_bad_q, net_bad_d;
  logic                   kv_q, kv_d;
  logic                   rv_q, rv_d;
  cpa_status_t            rs_q, rs_d;
  logic [`CPA_DATA_W-1:0] rdata_q, rdata_d;
  logic                   rflag_q, rflag_d;

  logic                   chk;
  logic [1:0]             idx;
  logic                   alg_ok;
  logic [`CPA_DATA_W-1:0] expect_net;

  assign alg_ok     = (dir_q == `CPA_DIR_APP) && right_q[0];
  assign expect_net = chal_q ^ {AUTH_KEY[15:0], AUTH_KEY[31:16]};

  always_comb begin
    code_d     = code_q;
    fail_d     = fail_q;
    blk_d      = blk_q;
    en_d       = en_q;
    right_d    = right_q;
    dir_d      = dir_q;
    lfsr_d     = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    chal_d     = chal_q;
    res_d      = res_q;
    part1_d    = part1_q;
    part2_d    = part2_q;
    key_d      = key_q;
    res_rdy_d  = res_rdy_q;
    res_sent_d = res_sent_q;
    chal_ok_d  = chal_ok_q;
    net_ok_d   = net_ok_q;
    net_bad_d  = net_bad_q;
    kv_d       = kv_q;
    rv_d       = 1'b0;
    rs_d       = ST_OK;
    rdata_d    = '0;
    rflag_d    = 1'b0;
    chk        = 1'b0;
    idx        = {1'b0, link.cmd_sel};
    if (link.cmd_valid) begin
      rv_d = 1'b1;
      case (link.cmd_op)
        OP_SELECT: begin
          dir_d = link.cmd_arg[`CPA_DIR_W-1:0];
        end
        OP_STATUS: begin
          rdata_d = {{(`CPA_DATA_W-`CPA_DIR_W){1'b0}}, dir_q};
        end
        OP_VERIFY: begin
          if (!link.cmd_sel && !en_q) begin
            right_d[0] = 1'b1;
          end else if (blk_q[idx]) begin
            rs_d = ST_BLOCKED;
          end else begin
            chk = 1'b1;
          end
        end
        OP_CHANGE: begin
          if (blk_q[idx] || (!link.cmd_sel && !en_q)) begin
            rs_d = ST_REFUSED;
          end else begin
            chk = 1'b1;
          end
        end
        OP_DISABLE: begin
          idx = 2'h0;
          if (!service_table_file[`CPA_SVC_DISABLE_BIT]) begin
            rs_d = ST_NO_SVC;
          end else if (blk_q[0] || !en_q) begin
            rs_d = ST_REFUSED;
          end else begin
            chk = 1'b1;
          end
        end
        OP_ENABLE: begin
          idx = 2'h0;
          if (blk_q[0] || en_q) begin
            rs_d = ST_REFUSED;
          end else begin
            chk = 1'b1;
          end
        end
        OP_UNBLOCK: begin
          idx = {1'b1, link.cmd_sel};
          if (blk_q[idx]) begin
            rs_d = ST_BLOCKED;
          end else begin
            chk = 1'b1;
          end
        end
        OP_ALG_CARD: begin
          if (!alg_ok) begin
            rs_d = ST_REFUSED;
          end else begin
            res_d      = link.cmd_arg ^ AUTH_KEY;
            part1_d    = ~(link.cmd_arg ^ AUTH_KEY) ^ {AUTH_KEY[7:0], AUTH_KEY[31:8]};
            res_rdy_d  = 1'b1;
            res_sent_d = 1'b0;
            kv_d       = 1'b0;
          end
        end
        OP_GET_RESP: begin
          if (!res_rdy_q) begin
            rs_d = ST_REFUSED;
          end else begin
            rdata_d    = res_q;
            rflag_d    = mutual_auth_setting_file;
            res_sent_d = 1'b1;
          end
        end
        OP_GET_CHAL: begin
          chal_d    = lfsr_q;
          rdata_d   = lfsr_q;
          chal_ok_d = 1'b1;
          net_ok_d  = 1'b0;
          net_bad_d = 1'b0;
        end
        OP_ALG_NET: begin
          if (!alg_ok || !chal_ok_q) begin
            rs_d = ST_REFUSED;
          end else if (link.cmd_arg == expect_net) begin
            net_ok_d = 1'b1;
            part2_d  = expect_net ^ {AUTH_KEY[23:0], AUTH_KEY[31:24]};
          end else begin
            net_bad_d = 1'b1;
            rs_d      = ST_MISMATCH;
          end
        end
        OP_KEY_COMB: begin
          if (!alg_ok || !(net_ok_q || res_sent_q) || net_bad_q) begin
            rs_d = ST_REFUSED;
          end else begin
            key_d      = part1_q ^ {part2_q[15:0], part2_q[31:16]};
            kv_d       = 1'b1;
            res_rdy_d  = 1'b0;
            res_sent_d = 1'b0;
            chal_ok_d  = 1'b0;
            net_ok_d   = 1'b0;
          end
        end
        OP_SES_END: begin
          right_d    = 2'h0;
          dir_d      = `CPA_DIR_MASTER;
          kv_d       = 1'b0;
          res_rdy_d  = 1'b0;
          res_sent_d = 1'b0;
          chal_ok_d  = 1'b0;
          net_ok_d   = 1'b0;
          net_bad_d  = 1'b0;
        end
        default: begin
          rs_d = ST_REFUSED;
        end
      endcase
    end
    if (chk) begin
      if (link.cmd_val == code_q[idx]) begin
        fail_d[idx] = 2'h0;
        case (link.cmd_op)
          OP_CHANGE: begin
            code_d[idx] = link.cmd_new;
            right_d[idx[0]] = 1'b1;
          end
          OP_DISABLE: begin
            en_d       = 1'b0;
            right_d[0] = 1'b1;
          end
          OP_ENABLE: begin
            en_d       = 1'b1;
            right_d[0] = 1'b1;
          end
          OP_UNBLOCK: begin
            blk_d[idx[0]]   = 1'b0;
            fail_d[idx[0]]  = 2'h0;
            code_d[idx[0]]  = link.cmd_new;
            right_d[idx[0]] = 1'b1;
          end
          default: begin
            right_d[idx[0]] = 1'b1;
          end
        endcase
      end else begin
        rs_d        = ST_MISMATCH;
        fail_d[idx] = fail_q[idx] + 2'h1;
        if (fail_q[idx] + 2'h1 == `CPA_MAX_FAILS) begin
          blk_d[idx] = 1'b1;
          if (!idx[1]) begin
            right_d[idx[0]] = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        code_q[i] <= CODE_RST[i];
        fail_q[i] <= 2'h0;
      end
      blk_q      <= 4'h0;
      en_q       <= 1'b1;
      right_q    <= 2'h0;
      dir_q      <= `CPA_DIR_MASTER;
      lfsr_q     <= `CPA_LFSR_RST;
      chal_q     <= '0;
      res_q      <= '0;
      part1_q    <= '0;
      part2_q    <= '0;
      key_q      <= '0;
      res_rdy_q  <= 1'b0;
      res_sent_q <= 1'b0;
      chal_ok_q  <= 1'b0;
      net_ok_q   <= 1'b0;
      net_bad_q  <= 1'b0;
      kv_q       <= 1'b0;
      rv_q       <= 1'b0;
      rs_q       <= ST_OK;
      rdata_q    <= '0;
      rflag_q    <= 1'b0;
    end else begin
      code_q     <= code_d;
      fail_q     <= fail_d;
      blk_q      <= blk_d;
      en_q       <= en_d;
      right_q    <= right_d;
      dir_q      <= dir_d;
      lfsr_q     <= lfsr_d;
      chal_q     <= chal_d;
      res_q      <= res_d;
      part1_q    <= part1_d;
      part2_q    <= part2_d;
      key_q      <= key_d;
      res_rdy_q  <= res_rdy_d;
      res_sent_q <= res_sent_d;
      chal_ok_q  <= chal_ok_d;
      net_ok_q   <= net_ok_d;
      net_bad_q  <= net_bad_d;
      kv_q       <= kv_d;
      rv_q       <= rv_d;
      rs_q       <= rs_d;
      rdata_q    <= rdata_d;
      rflag_q    <= rflag_d;
    end
  end

  // Answer carries the directory current after the command
  assign link.rsp_valid      = rv_q;
  assign link.rsp_status     = rs_q;
  assign link.rsp_data       = rdata_q;
  assign link.rsp_dir        = dir_q;
  assign link.rsp_flag       = rflag_q;
  assign access_right        = right_q;
  assign code_blocked        = blk_q;
  assign primary_enabled     = en_q;
  assign session_cipher_key  = key_q;
  assign key_valid           = kv_q;
endmodule

// ### hdl/cpa_term.sv
/*
  Terminal end: issues user commands, runs authentication sequences,
  supervises card presence during a call.
  Assumes the card answers each command with one rsp_valid pulse.
*/
`timescale 1ns/1ps
`include "cpa_regs.svh"
module cpa_term
  import cpa_pkg::*;
#(
  parameter int unsigned STATUS_CYC = `CPA_STATUS_PERIOD_S * `CPA_CLK_HZ - 2,
  parameter int unsigned RSP_CYC    = `CPA_RSP_LIMIT_S * `CPA_CLK_HZ - 2
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // Link to card
  cpa_link_if.term                    link,
  // User request
  input  wire logic                   req_valid,
  input  wire cpa_op_t                req_op,
  input  wire cpa_auth_t              req_auth,
  input  wire logic                   req_sel,
  input  wire logic [`CPA_CODE_W-1:0] req_val,
  input  wire logic [`CPA_CODE_W-1:0] req_new,
  input  wire logic [`CPA_DATA_W-1:0] req_arg,
  input  wire logic [`CPA_DATA_W-1:0] net_answer,
  input  wire logic                   net_mutual,
  output logic                        req_ready,
  // Completion
  output logic                        done_valid,
  output cpa_status_t                 done_status,
  output logic      [`CPA_DATA_W-1:0] done_data,
  // Call supervision
  input  wire logic                   in_call,
  input  wire logic [`CPA_SVC_W-1:0]  service_table_file,
  output logic                        call_end,
  output logic                        card_blocked
);
  typedef enum logic [1:0] {
    TS_IDLE = 2'h0,
    TS_WAIT = 2'h1
  } cpa_tstate_t;

  cpa_tstate_t            st_q, st_d;
  cpa_auth_t              am_q, am_d;
  logic                   cv_q, cv_d;
  cpa_op_t                op_q, op_d;
  logic                   sel_q, sel_d;
  logic [`CPA_CODE_W-1:0] val_q, val_d, new_q, new_d;
  logic [`CPA_DATA_W-1:0] arg_q, arg_d, nans_q, nans_d;
  logic [30:0]            idle_q, idle_d, wait_q, wait_d;
  logic [`CPA_DIR_W-1:0]  dir_q, dir_d;
  logic                   mut_q, mut_d;
  logic                   dv_q, dv_d, ce_q, ce_d, cb_q, cb_d, rdy_q, rdy_d;
  cpa_status_t            ds_q, ds_d;
  logic [`CPA_DATA_W-1:0] dd_q, dd_d;

  always_comb begin
    st_d   = st_q;
    am_d   = am_q;
    cv_d   = 1'b0;
    op_d   = op_q;
    sel_d  = sel_q;
    val_d  = val_q;
    new_d  = new_q;
    arg_d  = arg_q;
    nans_d = nans_q;
    dir_d  = dir_q;
    mut_d  = mut_q;
    cb_d   = cb_q;
    dv_d   = 1'b0;
    ce_d   = 1'b0;
    ds_d   = ds_q;
    dd_d   = dd_q;
    idle_d = (in_call && st_q == TS_IDLE) ? idle_q + 31'h1 : 31'h0;
    wait_d = wait_q + 31'h1;
    case (st_q)
      TS_IDLE: begin
        if (in_call && idle_q >= STATUS_CYC[30:0]) begin
          cv_d = 1'b1;
          op_d = OP_STATUS;
          am_d = AM_NONE;
          st_d = TS_WAIT;
          wait_d = 31'h0;
        end else if (req_valid) begin
          if (req_op == OP_DISABLE && !service_table_file[`CPA_SVC_DISABLE_BIT]) begin
            dv_d = 1'b1;
            ds_d = ST_NO_SVC;
          end else begin
            cv_d   = 1'b1;
            am_d   = req_auth;
            sel_d  = req_sel;
            val_d  = req_val;
            new_d  = req_new;
            arg_d  = req_arg;
            nans_d = net_answer;
            mut_d  = net_mutual;
            op_d   = (req_auth == AM_CARD) ? OP_ALG_CARD :
                     (req_auth == AM_NET) ? OP_GET_CHAL : req_op;
            st_d   = TS_WAIT;
            wait_d = 31'h0;
          end
        end
      end
      TS_WAIT: begin
        if (link.rsp_valid) begin
          st_d = TS_IDLE;
          if (op_q == OP_STATUS && in_call && link.rsp_dir != dir_q) begin
            ce_d = 1'b1;
          end
          dir_d = link.rsp_dir;
          if (op_q == OP_VERIFY && !sel_q) begin
            cb_d = (link.rsp_status != ST_OK);
          end
          ds_d = link.rsp_status;
          dd_d = link.rsp_data;
          dv_d = (op_q != OP_STATUS);
          if (am_q != AM_NONE && link.rsp_status == ST_OK && op_q != OP_KEY_COMB) begin
            dv_d = 1'b0;
            cv_d = 1'b1;
            st_d = TS_WAIT;
            wait_d = 31'h0;
            case (op_q)
              OP_ALG_CARD: op_d = OP_GET_RESP;
              OP_GET_RESP: op_d = (am_q == AM_CARD && link.rsp_flag) ?
                                  OP_GET_CHAL : OP_KEY_COMB;
              OP_GET_CHAL: begin
                op_d  = OP_ALG_NET;
                arg_d = nans_q;
              end
              OP_ALG_NET:  op_d = (am_q == AM_NET && mut_q) ?
                                  OP_ALG_CARD : OP_KEY_COMB;
              default:     op_d = OP_KEY_COMB;
            endcase
          end
        end else if (wait_q >= RSP_CYC[30:0]) begin
          st_d = TS_IDLE;
          ce_d = in_call;
          dv_d = (op_q != OP_STATUS);
          ds_d = ST_NO_RSP;
        end
      end
      default: begin
        st_d = TS_IDLE;
      end
    endcase
    // Ready drops ahead of a due presence check so no request is lost
    rdy_d = (st_d == TS_IDLE) && !cv_d && (idle_d < STATUS_CYC[30:0]);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= TS_IDLE;
      am_q   <= AM_NONE;
      cv_q   <= 1'b0;
      op_q   <= OP_NONE;
      sel_q  <= 1'b0;
      val_q  <= '0;
      new_q  <= '0;
      arg_q  <= '0;
      nans_q <= '0;
      idle_q <= 31'h0;
      wait_q <= 31'h0;
      dir_q  <= `CPA_DIR_MASTER;
      mut_q  <= 1'b0;
      dv_q   <= 1'b0;
      ce_q   <= 1'b0;
      cb_q   <= 1'b0;
      ds_q   <= ST_OK;
      dd_q   <= '0;
      rdy_q  <= 1'b1;
    end else begin
      st_q   <= st_d;
      am_q   <= am_d;
      cv_q   <= cv_d;
      op_q   <= op_d;
      sel_q  <= sel_d;
      val_q  <= val_d;
      new_q  <= new_d;
      arg_q  <= arg_d;
      nans_q <= nans_d;
      idle_q <= idle_d;
      wait_q <= wait_d;
      dir_q  <= dir_d;
      mut_q  <= mut_d;
      dv_q   <= dv_d;
      ce_q   <= ce_d;
      cb_q   <= cb_d;
      ds_q   <= ds_d;
      dd_q   <= dd_d;
      rdy_q  <= rdy_d;
    end
  end

  assign link.cmd_valid = cv_q;
  assign link.cmd_op    = op_q;
  assign link.cmd_sel   = sel_q;
  assign link.cmd_val   = val_q;
  assign link.cmd_new   = new_q;
  assign link.cmd_arg   = arg_q;
  assign req_ready      = rdy_q;
  assign done_valid     = dv_q;
  assign done_status    = ds_q;
  assign done_data      = dd_q;
  assign call_end       = ce_q;
  assign card_blocked   = cb_q;
endmodule

// ### bench/cpa_link_chk.sv
/*
  Checker for the card command link, watching both ends.
  Assumes one clock; instantiated beside the link in the bench.
*/
`timescale 1ns/1ps
`include "cpa_regs.svh"
module cpa_link_chk
  import cpa_pkg::*;
(
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  // Link signals
  input wire logic                  cmd_valid,
  input wire cpa_op_t               cmd_op,
  input wire logic                  rsp_valid,
  input wire cpa_status_t           rsp_status,
  input wire logic [`CPA_DIR_W-1:0] rsp_dir,
  input wire logic                  rsp_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_rsp_follows: assert property (cmd_valid |=> rsp_valid)
    else $error("no answer one cycle after a command");
  chk_rsp_caused: assert property (rsp_valid |-> $past(cmd_valid))
    else $error("answer without a command");
  chk_cmd_spacing: assert property (cmd_valid |=> !cmd_valid)
    else $error("command sent while one is outstanding");
  chk_alg_gate: assert property (cmd_valid && cmd_op inside {OP_ALG_CARD, OP_ALG_NET}
    && rsp_dir != `CPA_DIR_APP |=> rsp_status == ST_REFUSED)
    else $error("algorithm run outside the application directory");
  chk_dir_stable: assert property (!(cmd_valid && cmd_op inside {OP_SELECT, OP_SES_END})
    |=> $stable(rsp_dir))
    else $error("directory changed without a select");
  chk_resp_after_card: assert property (cmd_valid && cmd_op == OP_ALG_CARD
    ##1 rsp_status == ST_OK |=> cmd_valid && cmd_op == OP_GET_RESP)
    else $error("card algorithm not followed by get response");
  chk_net_after_chal: assert property (cmd_valid && cmd_op == OP_GET_CHAL
    ##1 rsp_status == ST_OK |=> cmd_valid && cmd_op == OP_ALG_NET)
    else $error("challenge not followed by network algorithm");
  chk_key_after_resp: assert property (rsp_valid && rsp_status == ST_OK && !rsp_flag
    && $past(cmd_op) == OP_GET_RESP |=> cmd_valid && cmd_op == OP_KEY_COMB)
    else $error("key combining missing after get response");
endmodule

// ### bench/card_pin_access_control_bench.sv
/*
  Bench for both link ends: drives the terminal user side, checks card state.
  Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/1ps
`include "cpa_regs.svh"
module card_pin_access_control_bench;
  import cpa_pkg::*;
  localparam logic [3:0] K_OK  = {1'b1, ST_OK};
  localparam logic [3:0] K_MIS = {1'b1, ST_MISMATCH};
  localparam logic [3:0] K_BLK = {1'b1, ST_BLOCKED};
  localparam logic [3:0] K_REF = {1'b1, ST_REFUSED};
  localparam logic [3:0] K_SVC = {1'b1, ST_NO_SVC};
  logic                   clk_sys = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   req_valid = 1'b0;
  cpa_op_t                req_op = OP_NONE;
  cpa_auth_t              req_auth = AM_NONE;
  logic                   req_sel = 1'b0;
  logic [`CPA_CODE_W-1:0] req_val = 16'h0000;
  logic [`CPA_CODE_W-1:0] req_new = 16'h0000;
  logic [`CPA_DATA_W-1:0] req_arg = 32'h0000_0000;
  logic [`CPA_DATA_W-1:0] net_answer = 32'h0000_0000;
  logic                   net_mutual = 1'b0;
  logic                   in_call = 1'b0;
  logic [`CPA_SVC_W-1:0]  service_table_file = 32'h0000_0000;
  logic                   mutual_auth_setting_file = 1'b0;
  logic                   req_ready;
  logic                   done_valid;
  cpa_status_t            done_status;
  logic [`CPA_DATA_W-1:0] done_data;
  logic                   call_end;
  logic                   card_blocked;
  logic [1:0]             access_right;
  logic [3:0]             code_blocked;
  logic                   primary_enabled;
  logic [`CPA_DATA_W-1:0] session_cipher_key;
  logic                   key_valid;
  logic [31:0]            rs = 32'h0000_005c;
  logic [15:0]            sec;
  logic [3:0]             exp_q[$];
  int                     bad_count = 0;
  int                     checked = 0;
  int                     ends = 0;
  int                     stats = 0;

  cpa_link_if link ();
  cpa_card cpa_card_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
    .service_table_file(service_table_file),
    .mutual_auth_setting_file(mutual_auth_setting_file), .access_right(access_right),
    .code_blocked(code_blocked), .primary_enabled(primary_enabled),
    .session_cipher_key(session_cipher_key), .key_valid(key_valid));
  cpa_term #(.STATUS_CYC(50), .RSP_CYC(20)) cpa_term_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(link), .req_valid(req_valid), .req_op(req_op), .req_auth(req_auth),
    .req_sel(req_sel), .req_val(req_val), .req_new(req_new), .req_arg(req_arg),
    .net_answer(net_answer), .net_mutual(net_mutual), .req_ready(req_ready),
    .done_valid(done_valid), .done_status(done_status), .done_data(done_data),
    .in_call(in_call), .service_table_file(service_table_file), .call_end(call_end),
    .card_blocked(card_blocked));
  cpa_link_chk cpa_link_chk_i (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(link.cmd_valid),
    .cmd_op(link.cmd_op), .rsp_valid(link.rsp_valid), .rsp_status(link.rsp_status),
    .rsp_dir(link.rsp_dir), .rsp_flag(link.rsp_flag));

  always #12.5 clk_sys = ~clk_sys;

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  // A code guaranteed to differ from the one given
  function automatic logic [15:0] bad(logic [15:0] c);
    logic [31:0] r;
    r = rnd();
    return c ^ (r[15:0] | 16'h0001);
  endfunction

  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic req(cpa_op_t op, cpa_auth_t au, logic sl, logic [15:0] v, logic [15:0] nw,
                     logic [31:0] a, logic [3:0] e);
    int n;
    while (req_ready !== 1'b1) @(negedge clk_sys);
    req_op = op;
    req_auth = au;
    req_sel = sl;
    req_val = v;
    req_new = nw;
    req_arg = a;
    req_valid = 1'b1;
    @(posedge clk_sys);
    exp_q.push_back(e);
    @(negedge clk_sys);
    req_valid = 1'b0;
    n = 0;
    while (done_valid !== 1'b1 && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    cmp("done_valid", 1'b1, done_valid);
    @(negedge clk_sys);
  endtask

  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Results are matched in order against the notes left by the driver
  always @(negedge clk_sys) begin
    if (link.cmd_valid === 1'b1 && link.cmd_op === OP_STATUS) stats++;
    if (call_end === 1'b1) ends++;
    if (done_valid === 1'b1 && exp_q.size() > 0) begin
      if (exp_q[0][3]) cmp("done_status", exp_q[0][2:0], done_status);
      void'(exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    summarize();
  end

  initial begin
    net_answer = rnd();
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    cmp("code_blocked", 4'h0, code_blocked);
    cmp("access_right", 2'h0, access_right);
    req(OP_ALG_CARD, AM_CARD, 1'b0, 16'h0, 16'h0, rnd(), K_REF);
    req(OP_SELECT, AM_NONE, 1'b0, 16'h0, 16'h0, `CPA_DIR_APP, K_OK);
    $display("test gating done");
    for (int i = 0; i < 6; i++) begin
      req(OP_VERIFY, AM_NONE, 1'b0, (i % 3 == 2) ? `CPA_PRI_RST : bad(`CPA_PRI_RST), 16'h0,
          32'h0, (i % 3 == 2) ? K_OK : K_MIS);
    end
    cmp("code_blocked", 4'h0, code_blocked);
    cmp("access_right", 1'b1, access_right[0]);
    req(OP_ALG_CARD, AM_CARD, 1'b0, 16'h0, 16'h0, rnd(), K_OK);
    cmp("key_valid", 1'b1, key_valid);
    cmp("key_set", 1'b1, |session_cipher_key);
    mutual_auth_setting_file = 1'b1;
    req(OP_ALG_CARD, AM_CARD, 1'b0, 16'h0, 16'h0, rnd(), K_MIS);
    cmp("key_valid", 1'b0, key_valid);
    net_mutual = 1'b1;
    req(OP_GET_CHAL, AM_NET, 1'b0, 16'h0, 16'h0, rnd(), K_MIS);
    cmp("key_valid", 1'b0, key_valid);
    $display("test verify and auth done");
    sec = 16'(rnd());
    req(OP_CHANGE, AM_NONE, 1'b1, bad(`CPA_SEC_RST), sec, 32'h0, K_MIS);
    req(OP_CHANGE, AM_NONE, 1'b1, `CPA_SEC_RST, sec, 32'h0, K_OK);
    req(OP_VERIFY, AM_NONE, 1'b1, sec, 16'h0, 32'h0, K_OK);
    req(OP_DISABLE, AM_NONE, 1'b0, `CPA_PRI_RST, 16'h0, 32'h0, K_SVC);
    service_table_file = 32'h0000_0001;
    req(OP_DISABLE, AM_NONE, 1'b0, `CPA_PRI_RST, 16'h0, 32'h0, K_OK);
    cmp("primary_enabled", 1'b0, primary_enabled);
    req(OP_VERIFY, AM_NONE, 1'b0, bad(`CPA_PRI_RST), 16'h0, 32'h0, K_OK);
    req(OP_ENABLE, AM_NONE, 1'b0, `CPA_PRI_RST, 16'h0, 32'h0, K_OK);
    cmp("primary_enabled", 1'b1, primary_enabled);
    $display("test change and enable done");
    for (int i = 0; i < 3; i++) begin
      req(OP_VERIFY, AM_NONE, 1'b0, bad(`CPA_PRI_RST), 16'h0, 32'h0, K_MIS);
    end
    cmp("code_blocked", 4'h1, code_blocked);
    cmp("access_right", 1'b0, access_right[0]);
    req(OP_VERIFY, AM_NONE, 1'b0, `CPA_PRI_RST, 16'h0, 32'h0, K_BLK);
    cmp("card_blocked", 1'b1, card_blocked);
    req(OP_UNBLOCK, AM_NONE, 1'b0, `CPA_PRI_UNBLK_RST, `CPA_PRI_RST, 32'h0, K_OK);
    cmp("code_blocked", 4'h0, code_blocked);
    $display("test blocking done");
    in_call = 1'b1;
    repeat (130) @(negedge clk_sys);
    in_call = 1'b0;
    cmp("status_sent", 1'b1, stats >= 2);
    cmp("call_end", 32'h0, ends);
    $display("test supervision done");
    summarize();
  end
endmodule
